// ### rtl/lic_pkg.sv
// Package for the LED indicator control block: map, fields, resets, timing
package lic_pkg;
    // Register map
    localparam logic [11:0] LED_CONTROL_OFS = 12'he00;
    localparam logic [11:0] EEPROM_LOAD_OFS = 12'he04;

    // Field positions within led_control, per LED stride of 8 bits
    localparam int SEL_LSB = 0;
    localparam int FLIP_BIT = 6;
    localparam int FLASH_BIT = 7;
    localparam int RATE_BIT = 5;
    localparam int LED_STRIDE = 8;
    localparam int NUM_LEDS = 4;

    // Writable bit mask: reserved bits 4, 12, 13, 20, 21, 28, 29 read zero
    localparam logic [31:0] CTRL_WMASK = 32'hcfcfcfef;

    // Built-in fallback of the configuration image
    localparam logic [31:0] CTRL_RESET = 32'h07068302;

    // Source selector codes
    localparam logic [3:0] SEL_LINK_10_1000 = 4'h0;
    localparam logic [3:0] SEL_LINK_100_1000 = 4'h1;
    localparam logic [3:0] SEL_LINK_UP = 4'h2;
    localparam logic [3:0] SEL_FILTER_ACT = 4'h3;
    localparam logic [3:0] SEL_LINK_IDLE = 4'h4;
    localparam logic [3:0] SEL_LINK_10 = 4'h5;
    localparam logic [3:0] SEL_LINK_100 = 4'h6;
    localparam logic [3:0] SEL_LINK_1000 = 4'h7;
    localparam logic [3:0] SEL_PIN_MIRROR = 4'h8;
    localparam logic [3:0] SEL_FULL_DUPLEX = 4'h9;
    localparam logic [3:0] SEL_COLLISION = 4'ha;
    localparam logic [3:0] SEL_ACTIVITY = 4'hb;
    localparam logic [3:0] SEL_BUS_SIZE = 4'hc;
    localparam logic [3:0] SEL_PAUSED = 4'hd;
    localparam logic [3:0] SEL_FORCE_LIT = 4'he;
    localparam logic [3:0] SEL_FORCE_DARK = 4'hf;

    // Blink timing; half period scaled by five for the slowed blink
    localparam longint CLK_HZ = 50000000;
    localparam longint SLOW_HALF_MS = 200;
    localparam longint FAST_HALF_MS = 83;
    localparam longint BLINK_SCALE = 5;
    localparam longint SLOW_HALF_CYC =
        SLOW_HALF_MS * BLINK_SCALE * CLK_HZ / 1000;
    localparam longint FAST_HALF_CYC =
        FAST_HALF_MS * BLINK_SCALE * CLK_HZ / 1000;

    // Link speed encoding
    typedef enum logic [1:0] {
        LIC_SPD_10 = 2'h0,
        LIC_SPD_100 = 2'h1,
        LIC_SPD_1000 = 2'h2
    } lic_speed_t;

    // Link status carried from the MAC/PHY
    typedef struct packed {
        logic link_up;
        lic_speed_t speed;
        logic full_duplex;
        logic filt_activity;
        logic activity;
        logic collision;
        logic bus_wide;
        logic tx_paused;
    } lic_link_t;

    // Configuration image from the EEPROM loader
    typedef struct packed {
        logic valid;
        logic [31:0] value;
    } lic_cfg_t;

    // Whole state of the block
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] blink_cnt;
        logic blink_phase;
        logic cfg_loaded;
        logic dp_pend;
        logic dp_write;
        logic [11:0] dp_addr;
        logic [31:0] rdata;
        logic [3:0] led;
    } lic_state_t;
endpackage : lic_pkg

// ### rtl/lic_led_control.sv
// LED indicator control: register, source select, invert and blink
`timescale 1ns/1ps
module lic_led_control (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire lic_pkg::lic_link_t LINK,
    input wire logic [3:0] SOFTWARE_PIN,
    input wire lic_pkg::lic_cfg_t CFG,
    output logic [3:0] LED
);
    lic_pkg::lic_state_t s_r;
    lic_pkg::lic_state_t s_nxt;
    logic [3:0] src;
    logic [31:0] half_cyc;
    logic wr_ctrl;
    logic [31:0] wr_val;
    logic [3:0] lit;

    // Source of one LED from its four-bit selector
    function automatic logic pick_source(input logic [3:0] sel,
                                         input lic_pkg::lic_link_t l,
                                         input logic pin);
        logic up;
        logic s10;
        logic s100;
        logic s1000;
        up = l.link_up;
        s10 = up && (l.speed == lic_pkg::LIC_SPD_10);
        s100 = up && (l.speed == lic_pkg::LIC_SPD_100);
        s1000 = up && (l.speed == lic_pkg::LIC_SPD_1000);
        case (sel)
            lic_pkg::SEL_LINK_10_1000: pick_source = s10 | s1000;
            lic_pkg::SEL_LINK_100_1000: pick_source = s100 | s1000;
            lic_pkg::SEL_LINK_UP: pick_source = up;
            lic_pkg::SEL_FILTER_ACT: pick_source = up & l.filt_activity;
            lic_pkg::SEL_LINK_IDLE: pick_source = up & ~l.activity;
            lic_pkg::SEL_LINK_10: pick_source = s10;
            lic_pkg::SEL_LINK_100: pick_source = s100;
            lic_pkg::SEL_LINK_1000: pick_source = s1000;
            lic_pkg::SEL_PIN_MIRROR: pick_source = pin;
            lic_pkg::SEL_FULL_DUPLEX: pick_source = up & l.full_duplex;
            lic_pkg::SEL_COLLISION: pick_source = l.collision;
            lic_pkg::SEL_ACTIVITY: pick_source = l.activity;
            lic_pkg::SEL_BUS_SIZE: pick_source = l.bus_wide;
            lic_pkg::SEL_PAUSED: pick_source = l.tx_paused;
            lic_pkg::SEL_FORCE_LIT: pick_source = 1'b1;
            lic_pkg::SEL_FORCE_DARK: pick_source = 1'b0;
            default: pick_source = 1'b0;
        endcase
    endfunction : pick_source

    // Sources of all four LEDs, one field group per stride
    always_comb begin
        for (int i = 0; i < lic_pkg::NUM_LEDS; i++) begin
            src[i] = pick_source(
                s_r.ctrl[i*lic_pkg::LED_STRIDE+lic_pkg::SEL_LSB +: 4],
                LINK, SOFTWARE_PIN[i]);
        end
    end

    // Half blink period, scaled by five
    assign half_cyc = s_r.ctrl[lic_pkg::RATE_BIT] ?
        32'(lic_pkg::FAST_HALF_CYC) : 32'(lic_pkg::SLOW_HALF_CYC);

    // Data phase write to the control register
    assign wr_ctrl = s_r.dp_pend && s_r.dp_write &&
        (s_r.dp_addr == lic_pkg::LED_CONTROL_OFS);
    assign wr_val = HWDATA & lic_pkg::CTRL_WMASK;

    // Next state
    always_comb begin
        s_nxt = s_r;
        lit = 4'h0;
        // Shared blink counter for every LED
        if (s_r.blink_cnt >= half_cyc - 32'h00000001) begin
            s_nxt.blink_cnt = 32'h00000000;
            s_nxt.blink_phase = ~s_r.blink_phase;
        end else begin
            s_nxt.blink_cnt = s_r.blink_cnt + 32'h00000001;
        end
        // Configuration image loads once; a bus write in the same cycle wins
        if (!s_r.cfg_loaded && CFG.valid) begin
            s_nxt.ctrl = CFG.value & lic_pkg::CTRL_WMASK;
            s_nxt.cfg_loaded = 1'b1;
        end
        if (wr_ctrl) begin
            s_nxt.ctrl = wr_val;
        end
        // Address phase capture
        s_nxt.dp_pend = 1'b0;
        if (HSEL && HREADY && HTRANS[1]) begin
            s_nxt.dp_pend = 1'b1;
            s_nxt.dp_write = HWRITE;
            s_nxt.dp_addr = HADDR[11:0];
            case (HADDR[11:0])
                lic_pkg::LED_CONTROL_OFS: s_nxt.rdata = s_nxt.ctrl;
                lic_pkg::EEPROM_LOAD_OFS:
                    s_nxt.rdata = {31'h00000000, s_r.cfg_loaded};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
        // Invert, then blink the asserted source
        for (int i = 0; i < lic_pkg::NUM_LEDS; i++) begin
            lit[i] = src[i] ^
                s_r.ctrl[i*lic_pkg::LED_STRIDE+lic_pkg::FLIP_BIT];
            if (s_r.ctrl[i*lic_pkg::LED_STRIDE+lic_pkg::FLASH_BIT]) begin
                s_nxt.led[i] = lit[i] & s_r.blink_phase;
            end else begin
                s_nxt.led[i] = lit[i];
            end
        end
    end

    // State register
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_r <= '0;
            s_r.ctrl <= lic_pkg::CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign HRDATA = s_r.rdata;
    assign HREADYOUT = 1'b1; // Zero wait states
    assign HRESP = 1'b0;
    assign LED = s_r.led;
endmodule : lic_led_control

// ### verif/lic_chk_assertions.sv
// Port checker for the LED indicator control block
`timescale 1ns/1ps
module lic_chk (
    input wire logic REF_CLK, RSTN, HSEL, HWRITE, HREADY, HREADYOUT, HRESP,
    input wire logic [1:0] HTRANS,
    input wire logic [31:0] HADDR, HWDATA, HRDATA,
    input wire lic_pkg::lic_link_t LINK,
    input wire logic [3:0] SOFTWARE_PIN, LED
);
    logic acc, wr_r;
    logic [31:0] d;
    // Accepted request, and a control write in its data phase
    assign acc = HSEL && HREADY && HTRANS[1];
    assign d = HWDATA;
    always_ff @(posedge REF_CLK or negedge RSTN)
        if (!RSTN) wr_r <= 1'b0;
        else wr_r <= acc && HWRITE && HADDR[11:0] == 12'he00;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    property p_rdy; HREADYOUT && !HRESP; endproperty
    a_rdy: assert property (p_rdy) else $error("bus stall");
    property p_gap; acc && !HWRITE && HADDR[11:3] != 9'h1c0 |=> !HRDATA;
    endproperty
    a_gap: assert property (p_gap) else $error("unmapped data");
    property p_res; acc && !HWRITE && HADDR[11:0] == 12'he00
        |=> !(HRDATA & ~lic_pkg::CTRL_WMASK); endproperty
    a_res: assert property (p_res) else $error("reserved set");
    property p_lit; wr_r && d[3:0] == 4'he && !d[7:6] |-> ##2 LED[0];
    endproperty
    a_lit: assert property (p_lit) else $error("lamp a");
    property p_flip; wr_r && d[19:16] == 4'he && d[23:22] == 2'h1
        |-> ##2 !LED[2]; endproperty
    a_flip: assert property (p_flip) else $error("lamp c");
    property p_dark; wr_r && d[11:8] == 4'hf && !d[14] |-> ##2 !LED[1];
    endproperty
    a_dark: assert property (p_dark) else $error("lamp b");
    property p_pin; wr_r && d[11:8] == 4'h8 && !d[15:14]
        |-> ##2 LED[1] == $past(SOFTWARE_PIN[1]); endproperty
    a_pin: assert property (p_pin) else $error("mirror");
    property p_spd; wr_r && d[27:24] == 4'h7 && !d[31:30] |-> ##2 LED[3]
        == $past(LINK.link_up && LINK.speed == lic_pkg::LIC_SPD_1000);
    endproperty
    a_spd: assert property (p_spd) else $error("lamp d");
    c_wr: cover property (wr_r);
    c_lit: cover property (LED == 4'hf);
    c_rd: cover property (acc && !HWRITE);
endmodule : lic_chk
bind lic_led_control lic_chk chk_u (.*);

// ### verif/lic_board.sv
// Board model of the four indicator lamps
`timescale 1ns/1ps
module lic_board (
    input wire logic [3:0] LED,
    output logic [3:0] glow
);
    // A lamp glows while its active high output is high
    assign glow = LED;
endmodule : lic_board

// ### verif/testbench.sv
// Random and corner bench for the LED indicator control block
`timescale 1ns/1ps
module testbench;
    logic REF_CLK = 1'b0, RSTN = 1'b0, HWRITE = 1'b0, HREADYOUT, HRESP;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, c, got;
    logic [3:0] SOFTWARE_PIN = 4'h0, LED, lamp, e;
    lic_pkg::lic_link_t LINK = '0;
    lic_pkg::lic_cfg_t CFG = '0;
    integer seed = 16435, n_mismatch = 0, checks_done = 0, cyc = 0, k, i;
    // Block, its lamps, clock and cycle ceiling
    lic_led_control dut_u (.REF_CLK, .RSTN, .HSEL(1'b1), .HADDR, .HTRANS,
        .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA,
        .HREADYOUT, .HRESP, .LINK, .SOFTWARE_PIN, .CFG, .LED);
    lic_board board_u (.LED, .glow(lamp));
    initial forever #10 REF_CLK = ~REF_CLK;
    always @(posedge REF_CLK) if (cyc++ == 5000) stop_test();
    // Lamp of one LED byte; the blink phase stays dark in this run
    function automatic logic lamp_of(input logic [7:0] f, input integer n);
        logic [2:0] s;
        logic [15:0] t;
        s = {3{LINK.link_up}} & (3'h1 << LINK.speed);
        t = {2'h1, LINK.tx_paused, LINK.bus_wide, LINK.activity,
            LINK.collision, LINK.link_up && LINK.full_duplex,
            SOFTWARE_PIN[n], s, LINK.link_up && !LINK.activity,
            LINK.link_up && LINK.filt_activity, LINK.link_up,
            s[1] | s[2], s[0] | s[2]};
        return f[7] ? 1'b0 : t[f[3:0]] ^ f[6];
    endfunction : lamp_of
    // One single transfer; read data kept in got
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        HTRANS <= 2'h2;
        HADDR <= {20'h0, a};
        HWRITE <= w;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge REF_CLK); while (HREADYOUT !== 1'b1);
        got = HRDATA;
    endtask : bus
    task automatic chk(input string n, input logic [31:0] x, y);
        checks_done++;
        n_mismatch += (x !== y);
        if (x !== y) $display("unexpected %s exp %h seen %h", n, x, y);
    endtask : chk
    task automatic stop_test;
        if (cyc > 5000) n_mismatch++;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    // Reset, one-time image load, then corner and random settings
    initial begin
        repeat (20) @(posedge REF_CLK);
        RSTN <= 1'b1;
        bus(1'b0, 12'he00, '0);
        chk("reset", lic_pkg::CTRL_RESET, got);
        bus(1'b0, 12'he04, '0);
        chk("status", 32'h00000000, got);
        c = $random(seed);
        CFG <= {1'b1, c};
        @(posedge REF_CLK);
        CFG.value <= ~c;
        bus(1'b0, 12'he00, '0);
        chk("image", c & lic_pkg::CTRL_WMASK, got);
        bus(1'b0, 12'he04, '0);
        chk("status", 32'h00000001, got);
        bus(1'b0, 12'he08, '0);
        chk("unmapped", '0, got);
        $display("load test done");
        for (k = 0; k < 200; k++) begin
            c = $random(seed) & lic_pkg::CTRL_WMASK;
            // Software habits: flash dynamic sources, no flip while flashing
            for (i = 0; i < 4; i++) begin
                if (c[8*i+:4] inside {4'h3, 4'h4, 4'ha, 4'hb, 4'hd})
                    c[8*i+7] = 1'b1;
                if (c[8*i+7]) c[8*i+6] = 1'b0;
            end
            if (k < 32) c = {4{1'b0, k[4], 2'h0, k[3:0]}};
            got = $random(seed);
            LINK <= {got[8], 2'(k % 3), got[5:0]};
            SOFTWARE_PIN <= got[12:9];
            bus(1'b1, 12'he00, c);
            repeat (2) @(posedge REF_CLK);
            #1;
            for (i = 0; i < 4; i++) e[i] = lamp_of(c[8*i+:8], i);
            chk("lamps", {28'h0, e}, {28'h0, lamp});
            bus(1'b0, 12'he00, '0);
            chk("control", c, got);
        end
        $display("random test done");
        stop_test();
    end
endmodule : testbench
